/* rtl/sfm_regs.vh */
// Register map, field positions and reset values of the filter and margin bank
`ifndef SFM_REGS_VH
`define SFM_REGS_VH
`define SFM_IDX_CAP_FIRST 8'h53
`define SFM_IDX_RES_THIRD 8'h54
`define SFM_IDX_CAP_THIRD 8'h55
`define SFM_IDX_MARGIN_CTRL 8'h56
`define SFM_IDX_STEP_BASE 8'h58
`define SFM_IDX_STEP_LAST 8'h67
`define SFM_IDX_SW_HI 8'h68
`define SFM_IDX_SW_LO 8'h69
`define SFM_IDX_OFFSET_OUT 8'h70
`define SFM_CAP_W 3
`define SFM_RES_W 7
`define SFM_OFS_W 10
`define SFM_OFS_HI_W 2
`define SFM_STEP_LSB 4
`define SFM_STEP_MSB 6
`define SFM_OPT_LSB 2
`define SFM_OPT_MSB 3
`define SFM_OPT_GATED 2'h0
`define SFM_OPT_PIN 2'h1
`define SFM_OPT_SW 2'h2
`define SFM_OPT_RSVD 2'h3
`define SFM_STEP_NOMINAL 3'h3
`define SFM_RST_ZERO 8'h00
// Step defaults packed 10 bits apiece, step 1 in the lowest slice
`define SFM_RST_STEP_ALL {10'h29E, 10'h247, 10'h1FE, 10'h1BE, 10'h186, 10'h14B, 10'h118, 10'h0DE}
`endif

/* rtl/sfm_sync2.v */
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module sfm_sync2 #(
  parameter W = 1
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_ff;
  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end
endmodule // sfm_sync2
`default_nettype wire

/* rtl/sfm_bank.v */
// Loop-filter codes and crystal margin control register bank
// What this block does
// (R1) First capacitor: 3-bit RW code, 5+50*code pF
// (R2) Third resistor: 7-bit RW code, reset zero
// (R3) Third capacitor: 3-bit RW code, 5*code pF
// (R4) Bits 6:4 read step pin level
// (R5) Readback 0..7 means steps 1..8, 3 nominal
// (R6) Bits 3:2 margin option, reset zero
// (R7) Option 0: pin step while gate low
// (R8) Option 1: pin step, gate ignored
// (R9) Option 2: offset from software register pair
// (R10) Eight steps, each 10-bit stored offset
// (R11) Software offset 10 bits over two registers
// (R12) Reserved bits zero; option 3 holds source
`include "sfm_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sfm_bank (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire margin_gate_pin_i,
  input wire [2:0] step_select_pin_i,
  output reg [2:0] synth_b_filter_cap_first_code_o,
  output reg [6:0] synth_b_filter_res_third_code_o,
  output reg [2:0] synth_b_filter_cap_third_code_o,
  output reg [9:0] crystal_offset_o,
  output reg [2:0] applied_step_o,
  output reg [1:0] offset_source_o
);
  localparam [1:0] SRC_GATED = `SFM_OPT_GATED;
  localparam [1:0] SRC_PIN = `SFM_OPT_PIN;
  localparam [1:0] SRC_SW = `SFM_OPT_SW;
  localparam [8*`SFM_OFS_W-1:0] RST_STEPS = `SFM_RST_STEP_ALL;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] opt_ff;
  reg [1:0] src_ff;
  reg [`SFM_OFS_HI_W-1:0] sw_hi_ff;
  reg [7:0] sw_lo_ff;
  reg [`SFM_OFS_W-1:0] step_mem [0:7];
  reg [31:0] nxt_rdata;
  reg [`SFM_OFS_W-1:0] nxt_offset;
  reg [2:0] nxt_step;
  wire [2:0] step_pin;
  wire gate_pin;
  wire wr_en;
  wire [7:0] wbyte;
  wire [7:0] step_rel;
  wire [2:0] step_idx;
  wire step_hit;
  integer k;

  // Pins come from outside the clock domain
  sfm_sync2 #(.W(4)) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({margin_gate_pin_i, step_select_pin_i}),
    .sync_o({gate_pin, step_pin})
  );

  // Registers are 8 bits wide except the 10-bit offset readback at 8'h70; only the low byte lane writes
  assign wr_en = avs_write_i && avs_byteenable_i[0] && state_ff == ST_ACK;
  assign wbyte = avs_writedata_i[7:0];
  assign step_rel = avs_address_i - `SFM_IDX_STEP_BASE;
  assign step_idx = step_rel[3:1];
  assign step_hit = avs_address_i >= `SFM_IDX_STEP_BASE && avs_address_i <= `SFM_IDX_STEP_LAST;

  // One wait cycle per access so read data comes from a flop
  always @*
  begin
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_IDLE: nxt_state = (avs_read_i || avs_write_i) ? ST_ACK : ST_IDLE;
      ST_ACK: nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @*
  begin
    nxt_rdata = 32'h0000_0000; // R12
    case (avs_address_i)
      `SFM_IDX_CAP_FIRST: nxt_rdata[`SFM_CAP_W-1:0] = synth_b_filter_cap_first_code_o; // R1
      `SFM_IDX_RES_THIRD: nxt_rdata[`SFM_RES_W-1:0] = synth_b_filter_res_third_code_o; // R2
      `SFM_IDX_CAP_THIRD: nxt_rdata[`SFM_CAP_W-1:0] = synth_b_filter_cap_third_code_o; // R3
      `SFM_IDX_MARGIN_CTRL:
      begin
        nxt_rdata[`SFM_STEP_MSB:`SFM_STEP_LSB] = step_pin; // R4
        nxt_rdata[`SFM_OPT_MSB:`SFM_OPT_LSB] = opt_ff; // R6
      end
      `SFM_IDX_SW_HI: nxt_rdata[`SFM_OFS_HI_W-1:0] = sw_hi_ff; // R11
      `SFM_IDX_SW_LO: nxt_rdata[7:0] = sw_lo_ff; // R11
      `SFM_IDX_OFFSET_OUT: nxt_rdata[`SFM_OFS_W-1:0] = crystal_offset_o;
      default:
      begin
        if (step_hit)
        begin
          if (step_rel[0])
            nxt_rdata[7:0] = step_mem[step_idx][7:0]; // R10
          else
            nxt_rdata[`SFM_OFS_HI_W-1:0] = step_mem[step_idx][`SFM_OFS_W-1:8]; // R10
        end
      end
    endcase
  end

  // Offset source selection; pin step 3 is the nominal load
  always @*
  begin
    nxt_step = step_pin;
    case (src_ff)
      SRC_GATED: nxt_step = gate_pin ? `SFM_STEP_NOMINAL : step_pin; // R7 R5
      SRC_PIN: nxt_step = step_pin; // R8
      default: nxt_step = step_pin;
    endcase
    if (src_ff == SRC_SW)
      nxt_offset = {sw_hi_ff, sw_lo_ff}; // R9
    else
      nxt_offset = step_mem[nxt_step]; // R5
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= ST_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      synth_b_filter_cap_first_code_o <= 3'h0;
      synth_b_filter_res_third_code_o <= 7'h00; // R2
      synth_b_filter_cap_third_code_o <= 3'h0;
      opt_ff <= 2'h0; // R6
      src_ff <= SRC_GATED;
      sw_hi_ff <= 2'h0;
      sw_lo_ff <= `SFM_RST_ZERO;
      for (k = 0; k < 8; k = k + 1)
        step_mem[k] <= RST_STEPS[k*`SFM_OFS_W +: `SFM_OFS_W]; // R10
      crystal_offset_o <= 10'h000;
      applied_step_o <= `SFM_STEP_NOMINAL;
      offset_source_o <= SRC_GATED;
    end
    else
    begin
      state_ff <= nxt_state;
      avs_waitrequest_o <= !(nxt_state == ST_ACK);
      if (state_ff == ST_IDLE && avs_read_i)
        avs_readdata_o <= nxt_rdata;
      if (wr_en)
      begin
        case (avs_address_i)
          `SFM_IDX_CAP_FIRST: synth_b_filter_cap_first_code_o <= wbyte[`SFM_CAP_W-1:0]; // R1
          `SFM_IDX_RES_THIRD: synth_b_filter_res_third_code_o <= wbyte[`SFM_RES_W-1:0]; // R2
          `SFM_IDX_CAP_THIRD: synth_b_filter_cap_third_code_o <= wbyte[`SFM_CAP_W-1:0]; // R3
          `SFM_IDX_MARGIN_CTRL:
          begin
            opt_ff <= wbyte[`SFM_OPT_MSB:`SFM_OPT_LSB]; // R6
            // Reserved option keeps whatever source was running
            if (wbyte[`SFM_OPT_MSB:`SFM_OPT_LSB] != `SFM_OPT_RSVD)
              src_ff <= wbyte[`SFM_OPT_MSB:`SFM_OPT_LSB]; // R12
          end
          `SFM_IDX_SW_HI: sw_hi_ff <= wbyte[`SFM_OFS_HI_W-1:0]; // R11
          `SFM_IDX_SW_LO: sw_lo_ff <= wbyte; // R11
          default:
          begin
            if (step_hit)
            begin
              if (step_rel[0])
                step_mem[step_idx][7:0] <= wbyte; // R10
              else
                step_mem[step_idx][`SFM_OFS_W-1:8] <= wbyte[`SFM_OFS_HI_W-1:0]; // R10
            end
          end
        endcase
      end
      crystal_offset_o <= nxt_offset;
      applied_step_o <= nxt_step;
      offset_source_o <= src_ff;
    end
  end
endmodule // sfm_bank
`default_nettype wire

/* test/sfm_pin_drv.sv */
// Board logic driving the margin gate and step-select pins
`timescale 1ns/1ps
`default_nettype none
module sfm_pin_drv (
  input wire logic core_clk_i,
  input wire logic gate_i,
  input wire logic [2:0] step_i,
  output logic margin_gate_pin_o,
  output logic [2:0] step_select_pin_o
);
  // Falling edge, so the pins are out of phase with the bank's sampling
  always @(negedge core_clk_i)
  begin
    margin_gate_pin_o <= gate_i;
    step_select_pin_o <= step_i;
  end
endmodule // sfm_pin_drv
`default_nettype wire

/* test/sfm_bank_checker.sv */
// Port assertions for the filter and margin bank
`timescale 1ns/1ps
`default_nettype none
module sfm_bank_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic margin_gate_pin_i,
  input wire logic [2:0] step_select_pin_i,
  input wire logic [6:0] synth_b_filter_res_third_code_o,
  input wire logic [2:0] applied_step_o,
  input wire logic [1:0] offset_source_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_vals: assert property ($rose(rst_n_i) |-> avs_waitrequest_o && offset_source_o == 2'h0
    && synth_b_filter_res_third_code_o == 7'h00) else $error("reset values wrong");
  a_ack_time: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("answer not one cycle after request");
  a_ack_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("ready longer than one cycle");
  a_read_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("read data moved without read");
  a_unmapped_zero: assert property ($rose(avs_read_i) && avs_address_i == 8'h57 |-> ##2 avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_step_follow: assert property (($stable(step_select_pin_i) && offset_source_o == 2'h1)[*4]
    |-> applied_step_o == step_select_pin_i) else $error("pin step not applied");
  a_gate_nominal: assert property (($stable(margin_gate_pin_i) && margin_gate_pin_i && offset_source_o == 2'h0)[*4]
    |-> applied_step_o == 3'h3) else $error("gate high but not nominal step");
  a_gate_open: assert property (($stable(step_select_pin_i) && !margin_gate_pin_i && offset_source_o == 2'h0)[*4]
    |-> applied_step_o == step_select_pin_i) else $error("gate low but pin step not applied");
endmodule // sfm_bank_checker
bind sfm_bank sfm_bank_checker sfm_bank_checker_i (.*);
`default_nettype wire

/* test/testbench.sv */
// Bench for the filter and margin register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, gate = 1, wq, gp;
  logic [7:0] adr = 0, wd = 0;
  logic [2:0] step = 0, c1, c3, ap, sp, e;
  logic [6:0] r3;
  logic [9:0] ofs;
  logic [1:0] src;
  logic [31:0] q, rdat;
  int num_errors = 0, total_checks = 0, cyc = 0;
  logic [9:0] tbl [8] = '{10'h0DE, 10'h118, 10'h14B, 10'h186, 10'h1BE, 10'h1FE, 10'h247, 10'h29E};
  sfm_bank sfm_bank_i (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i({24'h0, wd}), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .margin_gate_pin_i(gp), .step_select_pin_i(sp), .synth_b_filter_cap_first_code_o(c1),
    .synth_b_filter_res_third_code_o(r3), .synth_b_filter_cap_third_code_o(c3), .crystal_offset_o(ofs),
    .applied_step_o(ap), .offset_source_o(src));
  sfm_pin_drv sfm_pin_drv_i (.core_clk_i(clk), .gate_i(gate), .step_i(step), .margin_gate_pin_o(gp),
    .step_select_pin_o(sp));
  initial
    forever #2 clk = ~clk;
  task print_verdict;
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Run should need about 650 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    total_checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, x, s);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++)
    begin
      acc(0, 8'h53 + i, 0);
      chk("reset", 0, q);
      acc(1, 8'h53 + i, 8'hFF);
      acc(0, 8'h53 + i, 0);
      chk("field", i == 1 ? 32'h7F : i == 3 ? 32'h0C : 32'h07, q);
    end
    chk("codes", {c1, r3, c3}, {3'h7, 7'h7F, 3'h7});
    chk("src3", 0, src);
    acc(1, 8'h57, 8'hFF);
    acc(0, 8'h57, 0);
    chk("unmapped", 0, q);
    acc(1, 8'h68, 8'hFE);
    acc(1, 8'h69, 8'h5A);
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 16; s++)
      begin
        @(posedge clk);
        step <= s[2:0];
        gate <= s[3];
        acc(1, 8'h56, m << 2);
        repeat (5) @(posedge clk);
        acc(0, 8'h56, 0);
        chk("ctrl", {s[2:0], m[1:0], 2'b00}, q);
        e = (m == 0 && s[3]) ? 3'h3 : s[2:0];
        chk("src", m, src);
        if (m < 2)
          chk("step", e, ap);
        chk("ofs", m == 2 ? 10'h25A : tbl[e], ofs);
      end
    acc(1, 8'h56, 8'hFF);
    repeat (5) @(posedge clk);
    chk("hold", 2, src);
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
